/* inc/sapr_pkg.sv */
// Package of constants and types for the converter control block.
package sapr_pkg;
   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int CLK_PERIOD_NS   = 25;
   localparam int CONV_TIME_NS    = 610;
   localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int RST_SAMPLE_NS   = 20;
   localparam int RST_SAMPLE_CYC  =
      (RST_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ABORT_NS        = 50;
   localparam int ABORT_CYC       = ABORT_NS / CLK_PERIOD_NS;
   // ==========================================================================
   // Data layout
   // ==========================================================================
   localparam int RES_W           = 16;
   localparam int BYTE_W          = 8;
   localparam int FIFO_DEPTH      = 8;
   localparam logic [15:0] RES_RESET   = 16'h0000;
   localparam logic [7:0]  FILL_ONES   = 8'hFF;
   localparam logic [7:0]  LFSR_SEED   = 8'h5A;
   localparam logic [7:0]  LFSR_TAPS   = 8'hB8;
   // ==========================================================================
   // States
   // ==========================================================================
   typedef enum logic [1:0] {
      SAPR_RESTART = 2'b00,
      SAPR_SAMPLE  = 2'b01,
      SAPR_CONVERT = 2'b11,
      SAPR_WAIT_CS = 2'b10
   } sapr_state_t;
endpackage

/* src/sapr_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module sapr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // Read data comes from a register, so the head is loaded on a pop or
   // whenever the output stage is empty.
   assign push = in_valid && in_ready;
   assign pop  = out_ready && out_valid;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
      end else if (push) begin
         wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_ptr    <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if ((!out_valid || pop) && count != '0 &&
                   !(count == (AW+1)'(1) && out_valid)) begin
         out_data  <= mem[rd_ptr];
         out_valid <= 1'b1;
         rd_ptr    <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end else if (pop) begin
         out_valid <= 1'b0;
      end
   end

   // Count covers both the memory and the output register.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + 1'b1;
      end else if (pop && !push) begin
         count <= count - 1'b1;
      end
   end

   assign in_ready = (count < (AW+1)'(DEPTH));
endmodule // sapr_fifo

/* src/sapr_ctrl.sv */
// Convert trigger, busy, sampling restart and parallel readout logic.
`timescale 1ns/10ps
// Behaviour
// - The trigger's falling edge moves the converter from sample to hold.
// - Busy rises after the trigger falls and falls when conversion ends.
// - Sampling restarts at busy falling with select low, else at select fall.
// - The result bus is driven only while select and read are both low.
// - The result is straight binary with the MSB on the top bus line.
// - An internal timer ends each conversion within 610 ns.
// - Byte select folds the low result bits onto the upper bus lanes.
// - Byte select high gives low byte on top and all ones below.
// - Reset aborts conversion within 50 ns and clears the output latch.
// - The first sampling period starts at the first clock edge after reset release (20 ns rounded up to one 25 ns cycle).
module sapr_ctrl
   import sapr_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              conversion_trigger_n,
   input  wire logic              select_n,
   input  wire logic              read_n,
   input  wire logic              byte_sel,
   input  wire logic [RES_W-1:0]  analog_code,
   output logic                   busy,
   output logic                   sampling,
   output logic      [RES_W-1:0]  result_bus_out,
   output logic      [RES_W-1:0]  result_bus_oe,
   output logic                   fifo_overflow
);
   // =========================================================================
   // Edge detection and state
   // =========================================================================
   sapr_state_t state;
   logic        trig_q;
   logic        sel_q;
   logic        trig_fall;
   logic        sel_fall;
   logic [5:0]  conv_cnt;
   logic [1:0]  rst_cnt;
   logic [RES_W-1:0] held_code;
   logic [RES_W-1:0] result_latch;
   logic        conv_done;
   logic [RES_W-1:0] f_out;
   logic        f_valid;
   logic        f_in_ready;
   logic        f_pop;

   assign trig_fall = trig_q && !conversion_trigger_n;
   assign sel_fall  = sel_q && !select_n;
   assign conv_done = (state == SAPR_CONVERT) &&
                      (conv_cnt == 6'(CONV_CYC - 1));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         trig_q <= 1'b1;
         sel_q  <= 1'b1;
      end else begin
         trig_q <= conversion_trigger_n;
         sel_q  <= select_n;
      end
   end

   // Folded bus view of a result word, used for both the normal and byte
   // modes.
   function automatic logic [RES_W-1:0] fold(input logic [RES_W-1:0] w,
                                             input logic b);
      fold = b ? {w[BYTE_W-1:0], FILL_ONES} : w;
   endfunction

   // =========================================================================
   // Conversion sequencer
   // =========================================================================
   // A trigger is only honoured in sample state with select low; a trigger
   // while converting is ignored since the hold capacitor is already busy.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= SAPR_RESTART;
      end else begin
         unique case (state)
            SAPR_RESTART: begin
               if (rst_cnt == 2'(RST_SAMPLE_CYC - 1)) begin
                  state <= SAPR_SAMPLE;
               end
            end
            SAPR_SAMPLE: begin
               if (trig_fall && !select_n) begin
                  state <= SAPR_CONVERT;
               end
            end
            SAPR_CONVERT: begin
               if (conv_done) begin
                  state <= select_n ? SAPR_WAIT_CS : SAPR_SAMPLE;
               end
            end
            SAPR_WAIT_CS: begin
               if (sel_fall) begin
                  state <= SAPR_SAMPLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_cnt <= '0;
      end else if (state == SAPR_RESTART) begin
         rst_cnt <= rst_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         conv_cnt <= '0;
      end else if (state == SAPR_CONVERT && !conv_done) begin
         conv_cnt <= conv_cnt + 1'b1;
      end else begin
         conv_cnt <= '0;
      end
   end

   // Sample/hold: the input code is frozen at the trigger edge.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         held_code <= RES_RESET;
      end else if (state == SAPR_SAMPLE && trig_fall && !select_n) begin
         held_code <= analog_code;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy     <= 1'b0;
         sampling <= 1'b0;
      end else begin
         busy     <= (state == SAPR_SAMPLE && trig_fall && !select_n) ||
                     (state == SAPR_CONVERT && !conv_done);
         sampling <= (state == SAPR_RESTART &&
                      rst_cnt == 2'(RST_SAMPLE_CYC - 1)) ||
                     (state == SAPR_SAMPLE &&
                      !(trig_fall && !select_n)) ||
                     (state == SAPR_CONVERT && conv_done && !select_n) ||
                     (state == SAPR_WAIT_CS && sel_fall);
      end
   end

   // =========================================================================
   // Result path
   // =========================================================================
   // Results queue in a FIFO so a slow host that misses a read window does
   // not lose words; each completed read with byte select low pops the head.  The FIFO stalls
   // when the host reads nothing, and a result that finds it full is
   // dropped and flagged rather than overwriting older data.
   sapr_fifo #(
      .WIDTH (RES_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_data   (held_code),
      .in_valid  (conv_done),
      .in_ready  (f_in_ready),
      .out_data  (f_out),
      .out_valid (f_valid),
      .out_ready (f_pop)
   );

   logic rd_act;
   logic rd_act_q;
   assign rd_act = !select_n && !read_n;
   assign f_pop  = rd_act_q && !rd_act && byte_sel == 1'b0 &&
                   f_valid && result_latch == f_out;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_act_q <= 1'b0;
      end else begin
         rd_act_q <= rd_act;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fifo_overflow <= 1'b0;
      end else if (conv_done && !f_in_ready) begin
         fifo_overflow <= 1'b1;
      end
   end

   // The latch shows the oldest queued result; it clears on reset.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result_latch <= RES_RESET;
      end else if (f_valid) begin
         result_latch <= f_out;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result_bus_out <= RES_RESET;
         result_bus_oe  <= '0;
      end else begin
         result_bus_out <= fold(f_valid ? f_out : result_latch, byte_sel);
         result_bus_oe  <= {RES_W{rd_act}};
      end
   end

   // =========================================================================
   // Checks
   // =========================================================================
   sequence s_trigger;
      state == SAPR_SAMPLE && trig_fall && !select_n;
   endsequence

   // Four cycles is the shortest conversion that the timer may be set to.
   sequence s_busy_run;
      busy [*4];
   endsequence

   // Counts busy cycles so that the length of a whole conversion is checked
   // against the timer setting, independent of the sequencer's own counter.
   logic [5:0]  busy_len;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_len <= '0;
      end else if (busy) begin
         busy_len <= busy_len + 1'b1;
      end else begin
         busy_len <= '0;
      end
   end

   AST_BUSY_RISE: assert property (@(posedge clk) disable iff (!nrst)
      s_trigger |=> busy)
      else $error("busy did not rise after trigger");
   AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      s_trigger |=> s_busy_run)
      else $error("busy dropped early in conversion");
   AST_BUSY_END: assert property (@(posedge clk) disable iff (!nrst)
      s_trigger |-> ##[1:25] !busy)
      else $error("conversion exceeded its time");
   AST_BUSY_LEN: assert property (@(posedge clk) disable iff (!nrst)
      $fell(busy) |-> busy_len == 6'(CONV_CYC))
      else $error("busy length differs from conversion time");
   AST_HOLD_CODE: assert property (@(posedge clk) disable iff (!nrst)
      s_trigger |=> held_code == $past(analog_code))
      else $error("held code not captured at trigger");
   AST_BUS_OE: assert property (@(posedge clk) disable iff (!nrst)
      result_bus_oe[0] == $past(!select_n && !read_n))
      else $error("bus enable does not follow select and read");
   AST_FOLD: assert property (@(posedge clk) disable iff (!nrst)
      $past(byte_sel) |-> result_bus_out[BYTE_W-1:0] == FILL_ONES)
      else $error("lower lanes not all ones in byte mode");
   AST_RESAMPLE: assert property (@(posedge clk) disable iff (!nrst)
      (state == SAPR_CONVERT && conv_done && !select_n) |=> sampling)
      else $error("sampling did not restart at busy fall");
   AST_WAIT_SEL: assert property (@(posedge clk) disable iff (!nrst)
      (state == SAPR_WAIT_CS && !sel_fall) |=> !sampling)
      else $error("sampling started without select fall");
   AST_FIRST_SAMPLE: assert property (@(posedge clk)
      $rose(nrst) |-> !sampling ##1 sampling)
      else $error("first sampling not 20 ns after reset");
endmodule // sapr_ctrl

/* testbench/sapr_host.sv */
// Host model that drives the converter's trigger, select and read pins.
`timescale 1ns/10ps
module sapr_host
   import sapr_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             busy,
   input  wire logic             sampling,
   input  wire logic [RES_W-1:0] result_bus_out,
   input  wire logic [RES_W-1:0] result_bus_oe,
   output logic                  conversion_trigger_n,
   output logic                  select_n,
   output logic                  read_n,
   output logic                  byte_sel,
   output logic      [RES_W-1:0] analog_code
);
   initial begin
      conversion_trigger_n = 1'b1;
      select_n             = 1'b1;
      read_n               = 1'b1;
      byte_sel             = 1'b0;
      analog_code          = 16'h0000;
   end
   // =========================================================================
   // Conversion
   // =========================================================================
   task automatic convert(input logic [15:0] code, input logic sel,
                          input logic hold, output int bc);
      int n;
      @(posedge clk);
      select_n <= sel;
      analog_code <= code;
      for (n = 0; n < 40 && sampling !== 1'b1; n++) @(negedge clk);
      // Six cycles cover the settling time and the quiet zone before the edge.
      repeat (6) @(posedge clk);
      conversion_trigger_n <= 1'b0;
      @(posedge clk);
      conversion_trigger_n <= 1'b1;
      analog_code <= ~code;
      if (!hold) select_n <= 1'b1;
      bc = 0;
      for (n = 0; n < 60; n++) begin
         @(negedge clk);
         if (busy === 1'b1) bc++;
         else if (bc > 0) break;
      end
      @(posedge clk);
      select_n <= 1'b1;
   endtask
   // =========================================================================
   // Readout
   // =========================================================================
   task automatic strobe(input logic s, input logic r,
                         output logic [15:0] d, output logic [15:0] o);
      @(posedge clk);
      select_n <= s;
      read_n <= r;
      @(negedge clk);
      @(negedge clk);
      d = result_bus_out;
      o = result_bus_oe;
      @(posedge clk);
      select_n <= 1'b1;
      read_n <= 1'b1;
   endtask
   task automatic read(input logic bs, output logic [15:0] d,
                       output logic [15:0] o);
      @(posedge clk);
      byte_sel <= bs;
      strobe(1'b0, 1'b0, d, o);
   endtask
endmodule // sapr_host

/* testbench/test_sar_adc_convert_and_parallel_read.sv */
// Self-checking bench for the converter control and readout block.
`timescale 1ns/10ps
module test_sar_adc_convert_and_parallel_read
   import sapr_pkg::*;
;
   localparam int CC = 4;
   typedef struct {
      logic [15:0] code;
      logic [15:0] word;
      logic [15:0] fold;
   } sapr_row_t;
   logic             clk, nrst, busy, sampling, fifo_overflow;
   logic             conversion_trigger_n, select_n, read_n, byte_sel;
   logic [RES_W-1:0] analog_code, result_bus_out, result_bus_oe;
   logic [15:0]      d, o;
   int               bc;
   int               num_errors;
   int               n_tests;
   sapr_row_t        rows [5] = '{
      '{16'h0000, 16'h0000, 16'h00FF},
      '{16'hFFFF, 16'hFFFF, 16'hFFFF},
      '{16'h8000, 16'h8000, 16'h00FF},
      '{16'h7FFF, 16'h7FFF, 16'hFFFF},
      '{16'hA5C3, 16'hA5C3, 16'hC3FF}};
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   sapr_ctrl #(.CONV_CYC(CC)) sapr_ctrl_i (.clk, .nrst,
      .conversion_trigger_n, .select_n, .read_n, .byte_sel, .analog_code,
      .busy, .sampling, .result_bus_out, .result_bus_oe, .fifo_overflow);
   sapr_host sapr_host_i (.clk, .busy, .sampling, .result_bus_out,
      .result_bus_oe, .conversion_trigger_n, .select_n, .read_n,
      .byte_sel, .analog_code);
   // =========================================================================
   // Checking and verdict
   // =========================================================================
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic release_chk();
      @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      chk(16'(sampling), 16'h0000);
      @(negedge clk);
      chk(16'(sampling), 16'h0001);
   endtask
   // =========================================================================
   // Main sequence
   // =========================================================================
   initial begin
      num_errors = 0;
      n_tests = 0;
      nrst = 1'b0;
      repeat (16) @(posedge clk);
      chk(result_bus_oe | result_bus_out, 16'h0000);
      chk(16'({busy, fifo_overflow}), 16'h0000);
      release_chk();
      repeat (3) begin
         sapr_host_i.convert(16'h0001, 1'b0, 1'b1, bc);
         sapr_host_i.read(1'b0, d, o);
      end
      foreach (rows[i]) begin
         sapr_host_i.convert(rows[i].code, 1'b0, 1'b1, bc);
         chk(16'(bc), 16'(CC));
         @(negedge clk);
         chk(16'(sampling), 16'h0001);
         sapr_host_i.read(1'b1, d, o);
         chk(d, rows[i].fold);
         chk(o, 16'hFFFF);
         sapr_host_i.read(1'b0, d, o);
         chk(d, rows[i].word);
      end
      sapr_host_i.convert(16'h1111, 1'b1, 1'b0, bc);
      chk(16'(bc), 16'h0000);
      for (int k = 1; k < 4; k++) begin
         sapr_host_i.strobe(k[1], k[0], d, o);
         chk(o, 16'h0000);
      end
      // One result more than the buffer holds; the last one must be dropped.
      for (int k = 0; k < FIFO_DEPTH + 1; k++) begin
         sapr_host_i.convert(16'h1000 + 16'(k), 1'b0, 1'b0, bc);
         chk(16'(bc), 16'(CC));
         @(negedge clk);
         chk(16'(sampling), 16'h0000);
      end
      chk(16'(fifo_overflow), 16'h0001);
      for (int k = 0; k < FIFO_DEPTH; k++) begin
         sapr_host_i.read(1'b0, d, o);
         chk(d, 16'h1000 + 16'(k));
      end
      fork
         sapr_host_i.convert(16'h2222, 1'b0, 1'b1, bc);
         begin
            repeat (10) @(posedge clk);
            nrst <= 1'b0;
            @(negedge clk);
            @(negedge clk);
            chk(16'({busy, sampling, fifo_overflow}), 16'h0000);
            chk(result_bus_out, 16'h0000);
         end
      join
      release_chk();
      close_out();
   end
   // The full sequence needs about 11 us; nearly twenty times that marks a hang.
   initial begin
      #200us;
      num_errors++;
      close_out();
   end
endmodule // test_sar_adc_convert_and_parallel_read
